// ==== hdl/ipc_defs.vh ====
`ifndef IPC_DEFS_VH
`define IPC_DEFS_VH
`define IPC_POWER_CONTROL_REGISTER_W 8
`define IPC_POWER_CONTROL_REGISTER_RST 8'h00
`define IPC_IDLE_BIT 0
`define IPC_RST_SYNC_LEN 2'h3
`define IPC_RST_CNT_W 2
`define IPC_RST_CNT_ZERO 2'h0
`define IPC_RST_CNT_ONE 2'h1
`define IPC_ST_W 3
`define IPC_ST_RUN 3'h1
`define IPC_ST_IDLE 3'h2
`define IPC_ST_WAKE_RST 3'h4
`endif

// ==== hdl/ipc_idle_ctrl.v ====
`include "ipc_defs.vh"

// Idle mode controller: holds the idle request bit and gates the CPU clock enable.
module ipc_idle_ctrl (
  input wire clk, // system clock, may stop at any time
  input wire rst_n, // asynchronous reset, active low
  input wire power_control_register_wr, // CPU writes the power control register this cycle
  input wire [`IPC_POWER_CONTROL_REGISTER_W-1:0] power_control_register_wdata, // data written to the power control register
  input wire instr_done, // CPU retires the current instruction this cycle
  input wire irq_pending, // an enabled interrupt is asserted
  input wire hw_reset_req, // external hardware reset request, active high
  output reg [`IPC_POWER_CONTROL_REGISTER_W-1:0] power_control_register_rdata, // power control register contents
  output reg cpu_clk_en, // CPU clock enable, low while idle
  output reg idle_active, // device is in idle mode
  output reg ram_block, // internal RAM access blocked
  output reg core_reset // internal reset to the core, active high
);

  localparam ST_RUN = `IPC_ST_RUN;
  localparam ST_IDLE = `IPC_ST_IDLE;
  localparam ST_WAKE_RST = `IPC_ST_WAKE_RST;
  localparam [`IPC_POWER_CONTROL_REGISTER_W-1:0] POWER_CONTROL_REGISTER_RST = `IPC_POWER_CONTROL_REGISTER_RST;

  // Current and next controller state, one-hot.
  reg [`IPC_ST_W-1:0] state_r;
  reg [`IPC_ST_W-1:0] state_nxt;
  // Stored power control register and its next value.
  reg [`IPC_POWER_CONTROL_REGISTER_W-1:0] power_control_register_r;
  wire [`IPC_POWER_CONTROL_REGISTER_W-1:0] power_control_register_nxt;
  // Wake window counter.
  reg [`IPC_RST_CNT_W-1:0] rst_cnt_r;
  reg [`IPC_RST_CNT_W-1:0] rst_cnt_nxt;
  // Idle bit written, waiting for the writing instruction to retire.
  reg idle_pend_r;
  reg idle_pend_nxt;
  // Next values of the registered outputs.
  reg cpu_clk_en_nxt;
  reg idle_active_nxt;
  reg ram_block_nxt;
  reg core_reset_nxt;

  // State decode.
  wire in_run;
  wire in_idle;
  wire in_wake;
  // Events of the current cycle.
  wire write_ok;
  wire write_idle;
  wire idle_req;
  reg enter_idle;
  reg wake_by_rst;
  reg wake_by_irq;
  reg rst_from_run;
  reg wake_start;
  reg wake_last;
  reg clear_idle_bit;
  wire load_rst;

  assign in_run = (state_r == ST_RUN);
  assign in_idle = (state_r == ST_IDLE);
  assign in_wake = (state_r == ST_WAKE_RST);

  // Writes are refused while idle and during the wake window.
  assign write_ok = in_run && power_control_register_wr;
  assign write_idle = write_ok && power_control_register_wdata[`IPC_IDLE_BIT];
  assign idle_req = idle_pend_r || write_idle;

  // Suspend only once the writing instruction has retired, and never under reset.
  always @* begin
    enter_idle = 1'b0;
    if (in_run && idle_req && instr_done && !hw_reset_req) begin
      enter_idle = 1'b1;
    end
  end

  // A hardware reset wins over an interrupt.
  always @* begin
    wake_by_rst = 1'b0;
    if (in_idle && hw_reset_req) begin
      wake_by_rst = 1'b1;
    end
  end

  // Any enabled interrupt ends idle.
  always @* begin
    wake_by_irq = 1'b0;
    if (in_idle && !hw_reset_req && irq_pending) begin
      wake_by_irq = 1'b1;
    end
  end

  // A reset while running also opens the wake window.
  always @* begin
    rst_from_run = 1'b0;
    if (in_run && hw_reset_req) begin
      rst_from_run = 1'b1;
    end
  end

  always @* begin
    wake_start = 1'b0;
    if (wake_by_rst || rst_from_run) begin
      wake_start = 1'b1;
    end
  end

  // Last cycle of the wake window.
  always @* begin
    wake_last = 1'b0;
    if (in_wake && (rst_cnt_r == `IPC_RST_CNT_ONE)) begin
      wake_last = 1'b1;
    end
  end

  // The idle request bit is cleared by hardware on every way out of idle.
  always @* begin
    clear_idle_bit = 1'b0;
    if (wake_by_rst || wake_by_irq || in_wake) begin
      clear_idle_bit = 1'b1;
    end
  end

  assign load_rst = wake_last;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (rst_from_run) begin
          state_nxt = ST_WAKE_RST;
        end else if (enter_idle) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // The program counter is untouched, so service returns to the next instruction.
        if (wake_by_rst) begin
          state_nxt = ST_WAKE_RST;
        end else if (wake_by_irq) begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAKE_RST: begin
        if (wake_last) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // The CPU runs a few instructions with RAM blocked before reset takes over.
  always @* begin
    rst_cnt_nxt = rst_cnt_r;
    if (wake_start) begin
      rst_cnt_nxt = `IPC_RST_SYNC_LEN;
    end else if (in_wake && (rst_cnt_r != `IPC_RST_CNT_ZERO)) begin
      rst_cnt_nxt = rst_cnt_r - `IPC_RST_CNT_ONE;
    end
  end

  always @* begin
    idle_pend_nxt = idle_pend_r;
    if (write_ok) begin
      idle_pend_nxt = power_control_register_wdata[`IPC_IDLE_BIT];
    end
    if (enter_idle || wake_last) begin
      idle_pend_nxt = 1'b0;
    end
  end

  // Each register bit takes the reset value, a write, or holds; the idle bit can also take a hardware clear.
  genvar gi;
  generate
    for (gi = 0; gi < `IPC_POWER_CONTROL_REGISTER_W; gi = gi + 1) begin : g_power_control_register_bit
      if (gi == `IPC_IDLE_BIT) begin : g_idle
        assign power_control_register_nxt[gi] = load_rst ? POWER_CONTROL_REGISTER_RST[gi] :
                              clear_idle_bit ? 1'b0 :
                              write_ok ? power_control_register_wdata[gi] :
                              power_control_register_r[gi];
      end else begin : g_other
        assign power_control_register_nxt[gi] = load_rst ? POWER_CONTROL_REGISTER_RST[gi] :
                              write_ok ? power_control_register_wdata[gi] :
                              power_control_register_r[gi];
      end
    end
  endgenerate

  // Only the CPU clock is gated; this block and the peripherals keep running.
  always @* begin
    cpu_clk_en_nxt = 1'b1;
    if (state_nxt == ST_IDLE) begin
      cpu_clk_en_nxt = 1'b0;
    end
  end

  // Idle is flagged from the cycle after the entering edge.
  always @* begin
    idle_active_nxt = 1'b0;
    if (state_nxt == ST_IDLE) begin
      idle_active_nxt = 1'b1;
    end
  end

  always @* begin
    ram_block_nxt = 1'b0;
    if (state_nxt == ST_WAKE_RST) begin
      ram_block_nxt = 1'b1;
    end
  end

  // The core reset pulse marks the end of the wake window.
  always @* begin
    core_reset_nxt = 1'b0;
    if (wake_last) begin
      core_reset_nxt = 1'b1;
    end
  end

  // Plain flops only, so a stopped clock holds every value.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Nothing but a write, an idle exit or a reset changes the register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_register_r <= POWER_CONTROL_REGISTER_RST;
    end else begin
      power_control_register_r <= power_control_register_nxt;
    end
  end

  // The counter is loaded as the wake window opens and only counts down inside it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= `IPC_RST_CNT_ZERO;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // A pending request survives until its instruction retires.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_pend_r <= 1'b0;
    end else begin
      idle_pend_r <= idle_pend_nxt;
    end
  end

  // The read copy shows the value stored at the same edge.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_register_rdata <= POWER_CONTROL_REGISTER_RST;
    end else begin
      power_control_register_rdata <= power_control_register_nxt;
    end
  end

  // The clock enable returns in the cycle after the wake edge.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= cpu_clk_en_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_active <= 1'b0;
    end else begin
      idle_active <= idle_active_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_block <= 1'b0;
    end else begin
      ram_block <= ram_block_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset <= 1'b0;
    end else begin
      core_reset <= core_reset_nxt;
    end
  end

endmodule

// ==== verif/ipc_cpu_model.sv ====
module ipc_cpu_model (
  input wire clk, // system clock
  input wire cpu_clk_en, // CPU retires nothing while low
  output logic power_control_register_wr, // register write strobe
  output logic [7:0] power_control_register_wdata, // write data
  output logic instr_done // instruction retired
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {power_control_register_wr, power_control_register_wdata, instr_done} = 10'h000;
  // Only t_idle follows an idle request with a no-operation instruction, then a write while idle; t_rst and t_arst follow theirs with a reset or an interrupt.
  task automatic exec(input logic w, input logic [7:0] d, input logic dn);
    @(negedge clk) {power_control_register_wr, power_control_register_wdata, instr_done} = {w, d, dn & cpu_clk_en};
    @(negedge clk) {power_control_register_wr, power_control_register_wdata, instr_done} = {1'b0, ~d, 1'b0};
  endtask
endmodule

// ==== verif/ipc_idle_ctrl_properties.sv ====
module ipc_idle_ctrl_props (
  input wire clk, rst_n, power_control_register_wr, instr_done, irq_pending, hw_reset_req,
  input wire [7:0] power_control_register_wdata, power_control_register_rdata,
  input wire cpu_clk_en, idle_active, ram_block, core_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = !idle_active && !ram_block && !hw_reset_req;
  property p_on; go && power_control_register_wr && power_control_register_wdata[0] && instr_done |=> idle_active; endproperty
  a_on: assert property (p_on) else $error("idle not entered");
  property p_last; go && power_control_register_wr && power_control_register_wdata[0] && !instr_done |=> !idle_active; endproperty
  a_last: assert property (p_last) else $error("idle too early");
  property p_gate; idle_active |-> !cpu_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("cpu clock running");
  property p_hold; idle_active && !irq_pending && !hw_reset_req |=> $stable(power_control_register_rdata); endproperty
  a_hold: assert property (p_hold) else $error("register changed");
  property p_wake; idle_active && irq_pending && !hw_reset_req |=> !idle_active && !power_control_register_rdata[0];
  endproperty
  a_wake: assert property (p_wake) else $error("no irq wake");
  property p_rst; idle_active && hw_reset_req |=> ram_block && !idle_active && !power_control_register_rdata[0];
  endproperty
  a_rst: assert property (p_rst) else $error("no reset wake");
  property p_win; $rose(ram_block) |-> ram_block[*3] ##1 !ram_block; endproperty
  a_win: assert property (p_win) else $error("bad block window");
  property p_core; $rose(ram_block) |-> ##3 core_reset; endproperty
  a_core: assert property (p_core) else $error("no core reset");
endmodule
bind ipc_idle_ctrl ipc_idle_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .power_control_register_wr(power_control_register_wr),
  .instr_done(instr_done), .irq_pending(irq_pending), .hw_reset_req(hw_reset_req),
  .power_control_register_wdata(power_control_register_wdata), .power_control_register_rdata(power_control_register_rdata), .cpu_clk_en(cpu_clk_en),
  .idle_active(idle_active), .ram_block(ram_block), .core_reset(core_reset));

// ==== verif/ipc_idle_ctrl_tb.sv ====
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module ipc_idle_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, irq = 0, hwr = 0;
  wire wr, dn, en, idle, blk, crst;
  wire [7:0] wd, rd;
  int n_fail = 0, check_count = 0;
  initial forever #50 clk = ~clk;
  ipc_idle_ctrl DUT (.clk(clk), .rst_n(rst_n), .power_control_register_wr(wr), .power_control_register_wdata(wd), .instr_done(dn),
    .irq_pending(irq), .hw_reset_req(hwr), .power_control_register_rdata(rd), .cpu_clk_en(en),
    .idle_active(idle), .ram_block(blk), .core_reset(crst));
  ipc_cpu_model cpu (.clk(clk), .cpu_clk_en(en), .power_control_register_wr(wr), .power_control_register_wdata(wd), .instr_done(dn));
  task conclude;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_idle;
    cpu.exec(1, 8'h01, 0);
    `CHK("idle", 1'b0, idle)
    cpu.exec(0, 8'h00, 1);
    `CHK("idle", 1'b1, idle)
    `CHK("en", 1'b0, en)
    cpu.exec(1, 8'h00, 1);
    `CHK("power_control_register", 8'h01, rd)
    @(negedge clk) irq = 1;
    @(negedge clk) irq = 0;
    `CHK("power_control_register", 8'h00, rd)
    `CHK("en", 1'b1, en)
    repeat (3) cpu.exec(0, 8'h00, 1);
    $display("t_idle done");
  endtask
  task t_rst;
    cpu.exec(1, 8'h05, 1);
    @(negedge clk) hwr = 1;
    @(negedge clk) hwr = 0;
    `CHK("blk", 1'b1, blk)
    `CHK("power_control_register", 8'h04, rd)
    `CHK("idle", 1'b0, idle)
    repeat (3) @(negedge clk);
    `CHK("crst", 1'b1, crst)
    `CHK("blk", 1'b0, blk)
    `CHK("power_control_register", 8'h00, rd)
    $display("t_rst done");
  endtask
  task t_arst;
    cpu.exec(1, 8'h01, 1);
    `CHK("idle", 1'b1, idle)
    @(negedge clk) rst_n = 0;
    @(negedge clk) `CHK("power_control_register", 8'h00, rd)
    `CHK("en", 1'b1, en)
    `CHK("idle", 1'b0, idle)
    rst_n = 1;
    cpu.exec(1, 8'h01, 1);
    `CHK("idle", 1'b1, idle)
    @(negedge clk) irq = 1;
    @(negedge clk) irq = 0;
    `CHK("idle", 1'b0, idle)
    $display("t_arst done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    t_idle;
    t_rst;
    t_arst;
    conclude;
  end
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
